/* pkg/frc_defs.vh */
// Constants for the frame readout and context control block.
// Assumes inclusion by frc_top and the bench; definitions only.
`ifndef FRC_DEFS_VH
`define FRC_DEFS_VH
// Register byte addresses (word index times four)
`define FRC_A_CTRL      8'h00
`define FRC_A_STATUS    8'h04
`define FRC_A_CMEM_ADDR 8'h08
`define FRC_A_CMEM_DATA 8'h0c
`define FRC_A_MOTION    8'h10
`define FRC_A_SET_A     8'h40
`define FRC_A_SET_B     8'h80
// Control field positions
`define FRC_C_STREAM    0
`define FRC_C_GLOBAL    1
`define FRC_C_SNAP      2
`define FRC_C_EMB_DATA  3
`define FRC_C_EMB_STAT  4
`define FRC_C_SLAVE     5
`define FRC_C_CTX_SEL   6
`define FRC_C_FAST_SW   7
`define FRC_C_HDR       8
// Per-set register indices
`define FRC_R_EXPO      4'd0
`define FRC_R_LINE_LEN  4'd1
`define FRC_R_FRAME_LEN 4'd2
`define FRC_R_ROW_BIN   4'd3
`define FRC_R_COL_BIN   4'd4
`define FRC_R_Y_START   4'd7
`define FRC_R_Y_END     4'd9
`define FRC_R_Y_INC     4'd10
`define FRC_R_X_INC     4'd11
`define FRC_R_GAIN_G1   4'd12
`define FRC_R_OP_MODE   4'd17
`define FRC_SET_REGS    20
// Reset values
`define FRC_RST_EXPO    16'h0010
`define FRC_RST_LINELEN 16'h0020
`define FRC_RST_FRMLEN  16'h0040
`define FRC_RST_YEND    16'h000f
`define FRC_RST_GAIN    16'h0010
`define FRC_RST_INC     16'h0001
// Structure
`define FRC_EMB_ROWS    2
`define FRC_EMB_LAST    2'd1
`define FRC_CMEM_WORDS  256
`define FRC_SHUT_NS     100
`define FRC_SHUT_CYC    ((`FRC_SHUT_NS + 4) / 5)
`endif

/* core/frc_cmem.v */
// Context memory, 256 words of 16 bits, registered read data.
// Assumes a single clock shared with the control core.
`timescale 1ns/1ps
module frc_cmem (
  // Clock
  input  wire        clk,
  // Write port
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [15:0] wr_data,
  // Read port
  input  wire [7:0]  rd_addr,
  output reg  [15:0] rd_data_q
);
  reg [15:0] mem [0:255];
  // Array write and registered read
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule

/* core/frc_pixel.v */
// Pixel path: horizontal bin or skip, then digital gain (1x to 15.9375x).
// Assumes gain is 4.4 fixed point, pixel strobe on the core clock.
`timescale 1ns/1ps
module frc_pixel (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Control
  input  wire        bin_en,
  input  wire        skip_en,
  input  wire [7:0]  gain,
  // Pixel in
  input  wire        pix_vld,
  input  wire [11:0] pix_in,
  // Pixel out
  output reg         out_vld_q,
  output reg  [11:0] out_q
);
  reg        half_q;
  reg [11:0] held_q;
  wire [12:0] pair_sum = {1'b0, held_q} + {1'b0, pix_in};
  wire [11:0] sample   = bin_en ? pair_sum[12:1] : pix_in;
  wire [7:0]  g_clip   = (gain < 8'h10) ? 8'h10 : gain;
  wire [19:0] prod     = sample * g_clip;
  wire        pair_dn  = (bin_en | skip_en) ? half_q : 1'b1;
  // Pair pixels of one colour plane, then scale and clip
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_q    <= 1'b0;
      held_q    <= 12'h000;
      out_vld_q <= 1'b0;
      out_q     <= 12'h000;
    end else begin
      out_vld_q <= pix_vld & pair_dn;
      if (pix_vld) begin
        half_q <= ~half_q;
        held_q <= pix_in;
        if (pair_dn) begin
          out_q <= (prod[19:16] != 4'h0) ? 12'hfff : prod[15:4];
        end
      end else begin
        half_q <= 1'b0;
      end
    end
  end
endmodule

/* core/frc_top.v */
// Frame readout sequencer with A/B context sets and context memory.
// Assumes Avalon-MM master on clk; trigger arrives asynchronously.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "frc_defs.vh"
module frc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Slave trigger pin
  input  wire        trigger,
  // Pixel source
  input  wire [11:0] pix_in,
  // Row control to array
  output reg         row_reset_q,
  output reg         row_read_q,
  output reg  [15:0] row_addr_q,
  output reg         row_bin_q,
  // Shutter control
  output reg         shutter_open_q,
  // Output stream
  output reg         frame_valid_q,
  output reg         line_valid_q,
  output reg  [11:0] dout_q,
  output reg  [1:0]  row_kind_q
);
  // One-hot sequencer states: idle, leading data rows, active rows,
  // trailing statistics rows and global-reset integration
  localparam ST_IDLE = 5'h01;
  localparam ST_LEAD = 5'h02;
  localparam ST_ACT  = 5'h04;
  localparam ST_TAIL = 5'h08;
  localparam ST_GRS  = 5'h10;

  // Software registers
  reg [15:0] ctrl_q;
  reg [7:0]  cmem_ptr_q;
  reg [15:0] motion_q;
  reg [15:0] set_a_q [0:`FRC_SET_REGS-1];
  reg [15:0] set_b_q [0:`FRC_SET_REGS-1];
  // Settings adopted per frame
  reg        sel_frame_q;
  reg        sel_expo_q;
  reg        sel_pend_q;
  reg [15:0] expo_q;
  reg [15:0] line_len_q, frame_len_q, y_start_q, y_end_q;
  reg        vbin_q, hbin_q, vskip_q, hskip_q, hdr_q;
  reg [7:0]  gain_q;
  // Sequencer position
  reg [4:0]  state_q;
  reg [15:0] col_q, line_q, rd_row_q, rst_row_q, shut_q;
  reg [1:0]  extra_q;
  // Trigger sync and mode tracking
  reg        trig_m_q, trig_s_q, trig_p_q;
  reg        bad_frame_q, mode_prev_q;
  integer    i;

  // Bus decode
  wire       sel_wr  = avs_write & ~avs_waitrequest;
  wire       in_set_a = avs_address[7:6] == 2'b01 && avs_address[5:2] < `FRC_SET_REGS;
  wire       in_set_b = avs_address[7:6] == 2'b10 && avs_address[5:2] < `FRC_SET_REGS;
  wire [4:0] set_ix  = {1'b0, avs_address[5:2]};
  wire       cmem_we = sel_wr && avs_address == `FRC_A_CMEM_DATA;
  wire [15:0] cmem_rd;
  wire       pv_out;
  wire [11:0] pd_out;
  wire       trig_rise = trig_s_q & ~trig_p_q;
  wire       row_step  = col_q + 16'h1 >= line_len_q;
  wire [15:0] row_inc  = vskip_q || vbin_q ? 16'h2 : 16'h1;
  // Pixel strobe: read rows only, with one blank column at each end of
  // a row, so line valid drops between rows and falls in the same cycle as frame valid
  wire        in_read   = (state_q == ST_ACT) && (line_q >= expo_q);
  wire        mid_row   = (col_q != 16'h0) && !row_step;
  wire        pix_vld   = in_read && mid_row;
  // Embedded rows carry line valid except in their first column
  wire        extra_row = (state_q == ST_LEAD) || (state_q == ST_TAIL);
  wire        extra_lv  = extra_row && (col_q != 16'h0);
  // Status word: mode, bad-frame mark, selector stages, state
  wire [15:0] status_w  = {7'h00, hdr_q, bad_frame_q, sel_frame_q, sel_expo_q, state_q};
  // Next values of the registered array and stream outputs
  wire        row_start = (state_q == ST_ACT) && (col_q == 16'h0);
  wire        rst_nxt   = row_start && (rst_row_q <= y_end_q);
  wire        read_nxt  = row_start && (line_q >= expo_q);
  wire        fv_nxt    = extra_row || (state_q == ST_ACT);
  wire        lv_nxt    = extra_lv || pv_out;
  wire [15:0] addr_nxt  = (col_q == 16'h0 && line_q < expo_q) ? rst_row_q : rd_row_q;
  wire [11:0] dout_nxt  = (state_q == ST_LEAD) ? ctrl_q[11:0]
                        : (state_q == ST_TAIL) ? expo_q[11:0] : pd_out;
  wire [1:0]  kind_nxt  = (state_q == ST_LEAD) ? 2'b01
                        : (state_q == ST_TAIL) ? 2'b10 : 2'b00;

  // Context memory, one pointer shared by write and read
  frc_cmem u_cmem (
    .clk       (clk),
    .wr_en     (cmem_we),
    .wr_addr   (cmem_ptr_q),
    .wr_data   (avs_writedata[15:0]),
    .rd_addr   (cmem_ptr_q),
    .rd_data_q (cmem_rd)
  );

  // Pixel path: bin or skip, then gain
  frc_pixel u_pix (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bin_en    (hbin_q),
    .skip_en   (hskip_q),
    .gain      (gain_q),
    .pix_vld   (pix_vld),
    .pix_in    (pix_in),
    .out_vld_q (pv_out),
    .out_q     (pd_out)
  );

  // Trigger pin synchroniser and edge detect
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_p_q <= 1'b0;
    end else begin
      trig_m_q <= trigger;
      trig_s_q <= trig_m_q;
      trig_p_q <= trig_s_q;
    end
  end

  // Bus slave: one wait cycle, then the access completes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_q          <= 16'h0000;
      cmem_ptr_q      <= 8'h00;
      motion_q        <= 16'h0000;
      for (i = 0; i < `FRC_SET_REGS; i = i + 1) begin
        set_a_q[i] <= 16'h0000;
        set_b_q[i] <= 16'h0000;
      end
      set_a_q[`FRC_R_EXPO]      <= `FRC_RST_EXPO;
      set_b_q[`FRC_R_EXPO]      <= `FRC_RST_EXPO;
      set_a_q[`FRC_R_LINE_LEN]  <= `FRC_RST_LINELEN;
      set_b_q[`FRC_R_LINE_LEN]  <= `FRC_RST_LINELEN;
      set_a_q[`FRC_R_FRAME_LEN] <= `FRC_RST_FRMLEN;
      set_b_q[`FRC_R_FRAME_LEN] <= `FRC_RST_FRMLEN;
      set_a_q[`FRC_R_Y_END]     <= `FRC_RST_YEND;
      set_b_q[`FRC_R_Y_END]     <= `FRC_RST_YEND;
      set_a_q[`FRC_R_GAIN_G1]   <= `FRC_RST_GAIN;
      set_b_q[`FRC_R_GAIN_G1]   <= `FRC_RST_GAIN;
      set_a_q[`FRC_R_X_INC]     <= `FRC_RST_INC;
      set_b_q[`FRC_R_X_INC]     <= `FRC_RST_INC;
      set_a_q[`FRC_R_Y_INC]     <= `FRC_RST_INC;
      set_b_q[`FRC_R_Y_INC]     <= `FRC_RST_INC;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= 32'h0000_0000;
        case (avs_address)
          `FRC_A_CTRL:      avs_readdata <= {16'h0000, ctrl_q};
          `FRC_A_STATUS:    avs_readdata <= {16'h0000, status_w};
          `FRC_A_CMEM_ADDR: avs_readdata <= {24'h000000, cmem_ptr_q};
          `FRC_A_CMEM_DATA: avs_readdata <= {16'h0000, cmem_rd};
          `FRC_A_MOTION:    avs_readdata <= {16'h0000, motion_q};
          default: begin
            if (in_set_a) avs_readdata <= {16'h0000, set_a_q[set_ix]};
            if (in_set_b) avs_readdata <= {16'h0000, set_b_q[set_ix]};
          end
        endcase
      end
      if (sel_wr) begin
        case (avs_address)
          `FRC_A_CTRL:      ctrl_q <= avs_writedata[15:0];
          `FRC_A_CMEM_ADDR: cmem_ptr_q <= avs_writedata[7:0];
          `FRC_A_MOTION:    motion_q <= avs_writedata[15:0];
          default: begin
            if (in_set_a) set_a_q[set_ix] <= avs_writedata[15:0];
            if (in_set_b) set_b_q[set_ix] <= avs_writedata[15:0];
          end
        endcase
      end
      // context memory pointer autoincrements on data write
      if (cmem_we) cmem_ptr_q <= cmem_ptr_q + 8'h01;
      // Snapshot request clears itself once global capture starts
      if (state_q == ST_GRS) ctrl_q[`FRC_C_SNAP] <= 1'b0;
    end
  end

  // Frame sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      col_q <= 16'h0;
      line_q <= 16'h0;
      rd_row_q <= 16'h0;
      rst_row_q <= 16'h0;
      extra_q <= 2'b00;
      shut_q <= 16'h0;
      sel_frame_q <= 1'b0;
      sel_expo_q <= 1'b0;
      sel_pend_q <= 1'b0;
      expo_q <= `FRC_RST_EXPO;
      line_len_q <= `FRC_RST_LINELEN;
      frame_len_q <= `FRC_RST_FRMLEN;
      y_start_q <= 16'h0;
      y_end_q <= `FRC_RST_YEND;
      vbin_q <= 1'b0;
      hbin_q <= 1'b0;
      vskip_q <= 1'b0;
      hskip_q <= 1'b0;
      hdr_q <= 1'b0;
      gain_q <= 8'h10;
      bad_frame_q <= 1'b0;
      mode_prev_q <= 1'b0;
    end else begin
      col_q <= row_step ? 16'h0 : col_q + 16'h1;
      case (state_q)
        ST_IDLE: begin
          col_q <= 16'h0;
          if (ctrl_q[`FRC_C_GLOBAL] && ctrl_q[`FRC_C_SNAP]) begin
            state_q <= ST_GRS;
            shut_q <= 16'h0;
          end else if (ctrl_q[`FRC_C_STREAM] &&
                       (!ctrl_q[`FRC_C_SLAVE] || trig_rise)) begin
            // Exposure follows the selector from this frame on, the other
            // settings follow it from the next frame, so the first frame after a
            // switch takes its exposure from the new set and the rest from the old.
            // selector picks set
            sel_frame_q <= sel_pend_q;
            sel_expo_q <= ctrl_q[`FRC_C_CTX_SEL];
            sel_pend_q <= sel_expo_q;
            expo_q <= ctrl_q[`FRC_C_CTX_SEL] ? set_b_q[`FRC_R_EXPO]
                                             : set_a_q[`FRC_R_EXPO];
            line_len_q <= sel_expo_q ? set_b_q[`FRC_R_LINE_LEN] : set_a_q[`FRC_R_LINE_LEN];
            frame_len_q <= sel_expo_q ? set_b_q[`FRC_R_FRAME_LEN]
                                      : set_a_q[`FRC_R_FRAME_LEN];
            y_start_q <= sel_expo_q ? set_b_q[`FRC_R_Y_START] : set_a_q[`FRC_R_Y_START];
            y_end_q <= sel_expo_q ? set_b_q[`FRC_R_Y_END] : set_a_q[`FRC_R_Y_END];
            vbin_q <= sel_expo_q ? set_b_q[`FRC_R_ROW_BIN][0] : set_a_q[`FRC_R_ROW_BIN][0];
            hbin_q <= sel_expo_q ? set_b_q[`FRC_R_COL_BIN][0] : set_a_q[`FRC_R_COL_BIN][0];
            vskip_q <= (sel_expo_q ? set_b_q[`FRC_R_Y_INC] : set_a_q[`FRC_R_Y_INC]) == 16'h3;
            hskip_q <= (sel_expo_q ? set_b_q[`FRC_R_X_INC] : set_a_q[`FRC_R_X_INC]) == 16'h3;
            gain_q <= sel_expo_q ? set_b_q[`FRC_R_GAIN_G1][7:0]
                                 : set_a_q[`FRC_R_GAIN_G1][7:0];
            hdr_q <= ctrl_q[`FRC_C_HDR] | ctrl_q[`FRC_C_FAST_SW];
            bad_frame_q <= ctrl_q[`FRC_C_HDR] != mode_prev_q;
            mode_prev_q <= ctrl_q[`FRC_C_HDR];
            rd_row_q <= y_start_q;
            rst_row_q <= y_start_q;
            line_q <= 16'h0;
            extra_q <= 2'b00;
            state_q <= ctrl_q[`FRC_C_EMB_DATA] ? ST_LEAD : ST_ACT;
          end
        end
        ST_LEAD: begin
          if (row_step) begin
            extra_q <= extra_q + 2'b01;
            if (extra_q == `FRC_EMB_LAST) begin
              extra_q <= 2'b00;
              state_q <= ST_ACT;
            end
          end
        end
        ST_ACT: begin
          if (row_step) begin
            line_q <= line_q + 16'h1;
            if (line_q >= expo_q) rd_row_q <= rd_row_q + row_inc;
            if (rst_row_q <= y_end_q) rst_row_q <= rst_row_q + row_inc;
            // Leave after the last read row of the window
            if (rd_row_q + row_inc > y_end_q && line_q >= expo_q) begin
              state_q <= ctrl_q[`FRC_C_EMB_STAT] ? ST_TAIL : ST_IDLE;
            end
          end
        end
        ST_TAIL: begin
          if (row_step) begin
            extra_q <= extra_q + 2'b01;
            if (extra_q == `FRC_EMB_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_GRS: begin
          shut_q <= shut_q + 16'h1;
          if (shut_q >= expo_q + `FRC_SHUT_CYC) begin
            rd_row_q <= y_start_q;
            line_q <= expo_q;
            state_q <= ST_ACT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Registered array and stream outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_reset_q <= 1'b0;
      row_read_q <= 1'b0;
      row_addr_q <= 16'h0;
      row_bin_q <= 1'b0;
      shutter_open_q <= 1'b0;
      frame_valid_q <= 1'b0;
      line_valid_q <= 1'b0;
      dout_q <= 12'h000;
      row_kind_q <= 2'b00;
    end else begin
      // Row pulses and address to the array
      row_reset_q <= rst_nxt;
      row_read_q <= read_nxt;
      row_addr_q <= addr_nxt;
      row_bin_q <= vbin_q;
      shutter_open_q <= state_q == ST_GRS;
      frame_valid_q <= fv_nxt;
      line_valid_q <= lv_nxt;
      // Stream data and row kind
      dout_q <= dout_nxt;
      row_kind_q <= kind_nxt;
    end
  end
endmodule

/* dv/frc_top_sva.sv */
// Port checker for frc_top: bus answer, row pulses, stream framing.
// Assumes binding onto frc_top, one clock domain.
`timescale 1ns/1ps
module frc_top_sva (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Bus
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Row and stream
  input wire        row_reset_q,
  input wire        row_read_q,
  input wire        shutter_open_q,
  input wire        frame_valid_q,
  input wire        line_valid_q,
  input wire [1:0]  row_kind_q
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_LV_IN_FV: assert property (line_valid_q |-> frame_valid_q)
    else $error("line valid outside frame");
  AST_KIND_STEADY: assert property (line_valid_q && $past(line_valid_q) |-> $stable(row_kind_q))
    else $error("row kind changed within a row");
  AST_READ_PULSE: assert property (row_read_q |=> !row_read_q)
    else $error("row read longer than one cycle");
  AST_RESET_PULSE: assert property (row_reset_q |=> !row_reset_q)
    else $error("row reset longer than one cycle");
  AST_SHUT_NO_DATA: assert property (shutter_open_q |-> !frame_valid_q)
    else $error("frame data while shutter open");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");
  AST_UPPER_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> avs_waitrequest && !frame_valid_q)
    else $error("outputs not idle after reset");
  // Main scenarios
  COV_FRAME: cover property ($rose(frame_valid_q));
  COV_EMB: cover property (line_valid_q && row_kind_q == 2'h1);
  COV_STAT: cover property (line_valid_q && row_kind_q == 2'h2);
  COV_SHUT: cover property ($fell(shutter_open_q));
endmodule

bind frc_top frc_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .row_reset_q(row_reset_q), .row_read_q(row_read_q), .shutter_open_q(shutter_open_q),
  .frame_valid_q(frame_valid_q), .line_valid_q(line_valid_q), .row_kind_q(row_kind_q));

/* dv/frc_isp_model.sv */
// Processor-side model: drives the frame trigger and tallies each frame.
// Assumes frc_top stream and row outputs on the shared clk.
`timescale 1ns/1ps
module frc_isp_model (
  // Clock and trigger
  input  wire        clk,
  input  wire        trig_req,
  output wire        trigger,
  // Device outputs
  input  wire        frame_valid_q,
  input  wire        line_valid_q,
  input  wire [1:0]  row_kind_q,
  input  wire        row_reset_q,
  input  wire        row_read_q,
  input  wire [15:0] row_addr_q,
  // Per-frame tallies
  output reg  [7:0]  frames,
  output reg  [7:0]  n_emb,
  output reg  [7:0]  n_pix,
  output reg  [7:0]  n_stat,
  output reg         order_ok,
  output reg         uniform,
  output reg  [31:0] expo_cyc
);
  reg  [7:0]  ce, cp, cs;
  reg         ok, un, sn, lv, fv;
  reg  [31:0] t, d0;
  reg  [31:0] rt [0:63];
  wire [31:0] dt = t - rt[row_addr_q[5:0]];
  assign trigger = trig_req;
  // Start with empty tallies
  initial begin
    t = 32'h0;
    frames = 8'h00;
    {lv, fv, sn, ok, un} = 5'b00011;
    {ce, cp, cs} = 24'h0;
  end
  // a frame after a mode switch is tallied, never judged here
  always @(posedge clk) begin
    t <= t + 32'h1;
    lv <= line_valid_q;
    fv <= frame_valid_q;
    if (row_reset_q)
      rt[row_addr_q[5:0]] <= t;
    if (row_read_q) begin
      sn <= 1'b1;
      if (!sn)
        d0 <= dt;
      else if (dt != d0)
        un <= 1'b0;
    end
    if (line_valid_q && !lv) begin
      case (row_kind_q)
        2'h1: begin
          ce <= ce + 8'h01;
          ok <= ok & (cp == 8'h00);
        end
        2'h2: cs <= cs + 8'h01;
        default: begin
          cp <= cp + 8'h01;
          ok <= ok & (cs == 8'h00);
        end
      endcase
    end
    if (fv && !frame_valid_q) begin
      frames <= frames + 8'h01;
      {n_emb, n_pix, n_stat} <= {ce, cp, cs};
      {order_ok, uniform, expo_cyc} <= {ok, un, d0};
      {ce, cp, cs} <= 24'h0;
      {sn, ok, un} <= 3'b011;
    end
  end
endmodule

/* dv/test_frame_readout_context_control.sv */
// Bench for frc_top: register, context memory, stream and trigger tests.
// Assumes frc_isp_model on the stream side and frc_defs.vh on the path.
`timescale 1ns/1ps
`include "frc_defs.vh"
module test_frame_readout_context_control;
  // Clock, reset, bus
  reg         clk, sys_rst, avs_read, avs_write, trig_req;
  reg  [7:0]  avs_address;
  reg  [31:0] avs_writedata, rdata, e0, cyc;
  reg  [11:0] pix_in;
  reg  [7:0]  f0;
  wire [31:0] avs_readdata, expo_cyc;
  wire        avs_waitrequest, trigger, row_reset_q, row_read_q, shutter_open_q;
  wire        frame_valid_q, line_valid_q, order_ok, uniform;
  wire [15:0] row_addr_q;
  wire [1:0]  row_kind_q;
  wire [7:0]  frames, n_emb, n_pix, n_stat;
  integer     fails, cmp_count, j;
  frc_top uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger(trigger),
    .pix_in(pix_in), .row_reset_q(row_reset_q), .row_read_q(row_read_q),
    .row_addr_q(row_addr_q), .row_bin_q(), .shutter_open_q(shutter_open_q),
    .frame_valid_q(frame_valid_q), .line_valid_q(line_valid_q), .dout_q(),
    .row_kind_q(row_kind_q));
  frc_isp_model u_isp (.clk(clk), .trig_req(trig_req), .trigger(trigger),
    .frame_valid_q(frame_valid_q), .line_valid_q(line_valid_q), .row_kind_q(row_kind_q),
    .row_reset_q(row_reset_q), .row_read_q(row_read_q), .row_addr_q(row_addr_q),
    .frames(frames), .n_emb(n_emb), .n_pix(n_pix), .n_stat(n_stat),
    .order_ok(order_ok), .uniform(uniform), .expo_cyc(expo_cyc));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pixel source and run limit
  always @(posedge clk) begin
    pix_in <= pix_in + 12'h001;
    cyc <= cyc + 32'h1;
    if (cyc == 32'd90000) begin
      fails = fails + 1;
      results;
    end
  end
  function [7:0] ra(input s, input [3:0] i);
    ra = (s ? `FRC_A_SET_B : `FRC_A_SET_A) + {2'b00, i, 2'b00};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] x, input [8*8:1] w);
    begin
      bus(1'b0, a, 32'h0);
      chk(rdata, x, w);
    end
  endtask
  // Wait for the end of the next frame
  task wf;
    begin
      f0 = frames;
      while (frames === f0) @(posedge clk);
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    {sys_rst, avs_read, avs_write, trig_req} = 4'b1000;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    pix_in = 12'h000;
    {fails, cmp_count, cyc} = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (j = 0; j < 2; j = j + 1) begin
      rc(ra(j[0], `FRC_R_EXPO), `FRC_RST_EXPO, "expo");
      rc(ra(j[0], `FRC_R_LINE_LEN), `FRC_RST_LINELEN, "linelen");
      rc(ra(j[0], `FRC_R_FRAME_LEN), `FRC_RST_FRMLEN, "frmlen");
      rc(ra(j[0], `FRC_R_Y_END), `FRC_RST_YEND, "yend");
      rc(ra(j[0], `FRC_R_Y_INC), `FRC_RST_INC, "yinc");
      rc(ra(j[0], `FRC_R_GAIN_G1), `FRC_RST_GAIN, "gain");
    end
    bus(1'b1, ra(1'b1, `FRC_R_GAIN_G1), 32'habcd_0020);
    rc(ra(1'b1, `FRC_R_GAIN_G1), 32'h0000_0020, "gain_b");
    bus(1'b1, 8'hfc, 32'hffff_ffff);
    rc(8'hfc, 32'h0, "unmapped");
    bus(1'b1, `FRC_A_CMEM_ADDR, 32'h0000_00fe);
    bus(1'b1, `FRC_A_CMEM_DATA, 32'h0000_1234);
    bus(1'b1, `FRC_A_CMEM_DATA, 32'h0000_beef);
    for (j = 0; j < 2; j = j + 1) begin
      bus(1'b1, `FRC_A_CMEM_ADDR, 32'h0000_00fe + j);
      rc(`FRC_A_CMEM_DATA, j ? 32'h0000_beef : 32'h0000_1234, "cmem");
    end
    // both sets keep one register layout; B differs in values only
    bus(1'b1, ra(1'b1, `FRC_R_Y_INC), 32'h0000_0003);
    bus(1'b1, ra(1'b1, `FRC_R_EXPO), 32'h0000_0020);
    bus(1'b1, `FRC_A_CTRL, 32'h0000_0019);
    wf;
    wf;
    chk(n_emb, 32'd2, "emb");
    chk(n_stat, 32'd2, "stat");
    chk(n_pix, 32'd16, "rows");
    chk(order_ok, 32'd1, "order");
    // Set switch in mid-frame, both directions
    for (j = 0; j < 2; j = j + 1) begin
      while (frame_valid_q !== 1'b1) @(posedge clk);
      bus(1'b1, `FRC_A_CTRL, j ? 32'h0000_0019 : 32'h0000_0059);
      wf;
      chk(n_pix, j ? 32'd8 : 32'd16, "frame_n");
      e0 = expo_cyc;
      wf;
      chk(n_pix, j ? 32'd8 : 32'd16, "frame_n1");
      chk(expo_cyc != e0, 32'd1, "expo_n1");
      chk(uniform, 32'd1, "uniform");
      wf;
      chk(n_pix, j ? 32'd16 : 32'd8, "frame_n2");
    end
    // Slave mode waits for the trigger
    while (frame_valid_q !== 1'b1) @(posedge clk);
    bus(1'b1, `FRC_A_CTRL, 32'h0000_0021);
    wf;
    repeat (3000) @(posedge clk);
    chk(frames, f0 + 8'd1, "no_trig");
    trig_req <= 1'b1;
    repeat (4) @(posedge clk);
    trig_req <= 1'b0;
    wf;
    chk(n_pix, 32'd16, "trig");
    // Global reset snapshot
    bus(1'b1, `FRC_A_CTRL, 32'h0000_0006);
    while (shutter_open_q !== 1'b1) @(posedge clk);
    while (shutter_open_q !== 1'b0) @(posedge clk);
    wf;
    chk(n_pix, 32'd16, "snap");
    rc(`FRC_A_CTRL, 32'h0000_0002, "snap_clr");
    results;
  end
endmodule
